// *** mdvu_map.vh ***
`ifndef MDVU_MAP_VH
`define MDVU_MAP_VH
// ==========================================================
// Operation codes on the issue port.
`define MDVU_OP_W            3
`define MDVU_OP_MUL_PAIR     3'h0
`define MDVU_OP_MADD_PAIR    3'h1
`define MDVU_OP_MSUB_PAIR    3'h2
`define MDVU_OP_MUL_GPR      3'h3
`define MDVU_OP_DIV          3'h4
// ==========================================================
// Datapath shape.
`define MDVU_DATA_W          32
`define MDVU_PAIR_W          64
`define MDVU_PAIR_SEL_W      2
`define MDVU_PAIR_COUNT      4
`define MDVU_GPR_IDX_W       5
`define MDVU_BOOTH_DIGITS    17
// ==========================================================
// Multiply pipeline depth in clocks from issue to result.
`define MDVU_MUL_LATENCY     5
// ==========================================================
// Divide full iteration count and the iterations the early-out check skips.
`define MDVU_DIV_ITER_FULL   6'h20
`define MDVU_DIV_SKIP_8      6'h17
`define MDVU_DIV_SKIP_16     6'h0f
`define MDVU_DIV_SKIP_24     6'h07
// ==========================================================
// Divide latency and repeat interval in clocks, signed then unsigned.
`define MDVU_DIV_LAT_S8      6'h0c
`define MDVU_DIV_LAT_U8      6'h0e
`define MDVU_DIV_LAT_S16     6'h14
`define MDVU_DIV_LAT_U16     6'h16
`define MDVU_DIV_LAT_S24     6'h1c
`define MDVU_DIV_LAT_U24     6'h1e
`define MDVU_DIV_LAT_S32     6'h24
`define MDVU_DIV_LAT_U32     6'h26
`define MDVU_DIV_CNT_W       6
`endif

// *** mdvu_pair_mem.v ***
`timescale 1ns/100ps
`default_nettype none
`include "mdvu_map.vh"
// ==========================================================
// Result pair store: one write port, two registered read ports.
module mdvu_pair_mem #(
  parameter DW    = `MDVU_PAIR_W,
  parameter AW    = `MDVU_PAIR_SEL_W,
  parameter DEPTH = `MDVU_PAIR_COUNT
) (
  input  wire          clock,
  input  wire          rst,
  input  wire          ce,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [DW-1:0] wr_data,
  input  wire [AW-1:0] rda_addr,
  output reg  [DW-1:0] rda_data,
  input  wire [AW-1:0] rdb_addr,
  output reg  [DW-1:0] rdb_data
);

  reg [DW-1:0] mem_r [0:DEPTH-1];

  // Each entry clears on reset and takes the write when addressed.
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1)
    begin : g_entry
      always @(posedge clock)
      begin
        if (rst)
          mem_r[gi] <= {DW{1'b0}};
        else if (ce && wr_en && (wr_addr == gi))
          mem_r[gi] <= wr_data;
      end
    end
  endgenerate

  // Reads are write-first so that a same-cycle write is seen at once.
  always @(posedge clock)
  begin
    if (rst)
    begin
      rda_data <= {DW{1'b0}};
      rdb_data <= {DW{1'b0}};
    end
    else if (ce)
    begin
      rda_data <= (wr_en && (wr_addr == rda_addr)) ? wr_data : mem_r[rda_addr];
      rdb_data <= (wr_en && (wr_addr == rdb_addr)) ? wr_data : mem_r[rdb_addr];
    end
  end

endmodule
`default_nettype wire

// *** mdvu_core.v ***
`timescale 1ns/100ps
`default_nettype none
`include "mdvu_map.vh"
module mdvu_core #(
  parameter DW = `MDVU_DATA_W
) (
  input  wire                          clock,
  input  wire                          rst,
  input  wire                          ce,
  input  wire                          issue_valid,
  input  wire [`MDVU_OP_W-1:0]         issue_op,
  input  wire                          issue_signed,
  input  wire [`MDVU_PAIR_SEL_W-1:0]   issue_pair,
  input  wire [`MDVU_GPR_IDX_W-1:0]    issue_dest,
  input  wire [DW-1:0]                 first_source_operand,
  input  wire [DW-1:0]                 second_source_operand,
  output wire                          issue_stall,
  output reg                           gpr_wr_valid,
  output reg  [`MDVU_GPR_IDX_W-1:0]    gpr_wr_idx,
  output reg  [DW-1:0]                 gpr_wr_data,
  output reg                           div_done,
  input  wire [`MDVU_PAIR_SEL_W-1:0]   pair_rd_sel,
  output wire [DW-1:0]                 high_result_register,
  output wire [DW-1:0]                 low_result_register,
  output wire                          div_busy
);

  localparam PW = 2 * DW;
  localparam ND = `MDVU_BOOTH_DIGITS;
  localparam EW = 2 * ND;

  // ==========================================================
  // Issue acceptance.
  reg  [`MDVU_DIV_CNT_W-1:0] div_cnt_r;
  // Busy drops in the result-write cycle, so the next issue lands on the write edge.
  assign div_busy    = (div_cnt_r > {{(`MDVU_DIV_CNT_W-1){1'b0}}, 1'b1});
  assign issue_stall = issue_valid && div_busy;
  wire accept     = issue_valid && !div_busy;
  wire accept_div = accept && (issue_op == `MDVU_OP_DIV);
  wire accept_mul = accept && (issue_op != `MDVU_OP_DIV);

  // ==========================================================
  // Stage 1 operand capture; a multiply can enter every cycle the divider is not busy.
  reg                        s1_v_r;
  reg [`MDVU_OP_W-1:0]       s1_op_r;
  reg                        s1_sg_r;
  reg [`MDVU_PAIR_SEL_W-1:0] s1_pair_r;
  reg [`MDVU_GPR_IDX_W-1:0]  s1_dst_r;
  reg [DW-1:0]               s1_a_r;
  reg [DW-1:0]               s1_b_r;

  always @(posedge clock)
  begin
    if (rst)
    begin
      s1_v_r    <= 1'b0;
      s1_op_r   <= `MDVU_OP_MUL_PAIR;
      s1_sg_r   <= 1'b0;
      s1_pair_r <= {`MDVU_PAIR_SEL_W{1'b0}};
      s1_dst_r  <= {`MDVU_GPR_IDX_W{1'b0}};
      s1_a_r    <= {DW{1'b0}};
      s1_b_r    <= {DW{1'b0}};
    end
    else if (ce)
    begin
      s1_v_r    <= accept_mul;
      s1_op_r   <= issue_op;
      s1_sg_r   <= issue_signed;
      s1_pair_r <= issue_pair;
      s1_dst_r  <= issue_dest;
      s1_a_r    <= first_source_operand;
      s1_b_r    <= second_source_operand;
    end
  end

  // ==========================================================
  // Radix-4 Booth array: one partial product per digit, summed in a chain.
  wire [PW-1:0] a_ext = {{DW{s1_sg_r & s1_a_r[DW-1]}}, s1_a_r};
  wire [EW:0]   b_ext = {{(EW-DW){s1_sg_r & s1_b_r[DW-1]}}, s1_b_r, 1'b0};
  wire [PW*(ND+1)-1:0] sum_chain;
  assign sum_chain[PW-1:0] = {PW{1'b0}};

  genvar gd;
  generate
    for (gd = 0; gd < ND; gd = gd + 1)
    begin : g_booth
      wire [2:0]    dig = b_ext[2*gd+2:2*gd];
      reg  [PW-1:0] pp;
      // Each digit selects 0, +-A or +-2A before its shift.
      always @*
      begin
        case (dig)
          3'h1, 3'h2: pp = a_ext;
          3'h3:       pp = {a_ext[PW-2:0], 1'b0};
          3'h4:       pp = ~{a_ext[PW-2:0], 1'b0} + {{(PW-1){1'b0}}, 1'b1};
          3'h5, 3'h6: pp = ~a_ext + {{(PW-1){1'b0}}, 1'b1};
          default:    pp = {PW{1'b0}};
        endcase
      end
      wire [PW-1:0] pp_sh = pp << (2 * gd);
      assign sum_chain[PW*(gd+2)-1:PW*(gd+1)] = sum_chain[PW*(gd+1)-1:PW*gd] + pp_sh;
    end
  endgenerate

  wire [PW-1:0] booth_prod = sum_chain[PW*(ND+1)-1:PW*ND];

  // ==========================================================
  // Stages 2 to 5 carry the product towards the result pairs.
  reg                        s2_v_r, s3_v_r, s4_v_r, s5_v_r;
  reg [`MDVU_OP_W-1:0]       s2_op_r, s3_op_r, s4_op_r, s5_op_r;
  reg [`MDVU_PAIR_SEL_W-1:0] s2_pair_r, s3_pair_r, s4_pair_r, s5_pair_r;
  reg [`MDVU_GPR_IDX_W-1:0]  s2_dst_r, s3_dst_r, s4_dst_r, s5_dst_r;
  reg [PW-1:0]               s2_p_r, s3_p_r, s4_p_r, s5_p_r;

  // The pipe moves on ce alone; an integer-side stall never holds it.
  always @(posedge clock)
  begin
    if (rst)
    begin
      s2_v_r <= 1'b0;
      s3_v_r <= 1'b0;
      s4_v_r <= 1'b0;
      s5_v_r <= 1'b0;
      s2_op_r <= `MDVU_OP_MUL_PAIR;
      s3_op_r <= `MDVU_OP_MUL_PAIR;
      s4_op_r <= `MDVU_OP_MUL_PAIR;
      s5_op_r <= `MDVU_OP_MUL_PAIR;
      s2_pair_r <= {`MDVU_PAIR_SEL_W{1'b0}};
      s3_pair_r <= {`MDVU_PAIR_SEL_W{1'b0}};
      s4_pair_r <= {`MDVU_PAIR_SEL_W{1'b0}};
      s5_pair_r <= {`MDVU_PAIR_SEL_W{1'b0}};
      s2_dst_r <= {`MDVU_GPR_IDX_W{1'b0}};
      s3_dst_r <= {`MDVU_GPR_IDX_W{1'b0}};
      s4_dst_r <= {`MDVU_GPR_IDX_W{1'b0}};
      s5_dst_r <= {`MDVU_GPR_IDX_W{1'b0}};
      s2_p_r <= {PW{1'b0}};
      s3_p_r <= {PW{1'b0}};
      s4_p_r <= {PW{1'b0}};
      s5_p_r <= {PW{1'b0}};
    end
    else if (ce)
    begin
      s2_v_r <= s1_v_r;
      s3_v_r <= s2_v_r;
      s4_v_r <= s3_v_r;
      s5_v_r <= s4_v_r;
      s2_op_r <= s1_op_r;
      s3_op_r <= s2_op_r;
      s4_op_r <= s3_op_r;
      s5_op_r <= s4_op_r;
      s2_pair_r <= s1_pair_r;
      s3_pair_r <= s2_pair_r;
      s4_pair_r <= s3_pair_r;
      s5_pair_r <= s4_pair_r;
      s2_dst_r <= s1_dst_r;
      s3_dst_r <= s2_dst_r;
      s4_dst_r <= s3_dst_r;
      s5_dst_r <= s4_dst_r;
      s2_p_r <= booth_prod;
      s3_p_r <= s2_p_r;
      s4_p_r <= s3_p_r;
      s5_p_r <= s4_p_r;
    end
  end

  // ==========================================================
  // Stage 5 accumulation against the pair read during stage 4.
  wire [PW-1:0] acc_rd;
  reg  [PW-1:0] mul_res;
  always @*
  begin
    case (s5_op_r)
      `MDVU_OP_MADD_PAIR: mul_res = acc_rd + s5_p_r;
      `MDVU_OP_MSUB_PAIR: mul_res = acc_rd - s5_p_r;
      default:            mul_res = s5_p_r;
    endcase
  end
  wire mul_pair_wr = s5_v_r && (s5_op_r != `MDVU_OP_MUL_GPR);

  // General-register result leaves from flops five clocks after issue.
  always @(posedge clock)
  begin
    if (rst)
    begin
      gpr_wr_valid <= 1'b0;
      gpr_wr_idx   <= {`MDVU_GPR_IDX_W{1'b0}};
      gpr_wr_data  <= {DW{1'b0}};
    end
    else if (ce)
    begin
      gpr_wr_valid <= s5_v_r && (s5_op_r == `MDVU_OP_MUL_GPR);
      gpr_wr_idx   <= s5_dst_r;
      gpr_wr_data  <= s5_p_r[DW-1:0];
    end
  end

  // ==========================================================
  // Divider: early-out classification of the dividend at issue.
  wire fit8  = issue_signed ? (&first_source_operand[DW-1:7])  | ~(|first_source_operand[DW-1:7])
                            : ~(|first_source_operand[DW-1:8]);
  wire fit16 = issue_signed ? (&first_source_operand[DW-1:15]) | ~(|first_source_operand[DW-1:15])
                            : ~(|first_source_operand[DW-1:16]);
  wire fit24 = issue_signed ? (&first_source_operand[DW-1:23]) | ~(|first_source_operand[DW-1:23])
                            : ~(|first_source_operand[DW-1:24]);
  wire neg_n = issue_signed & first_source_operand[DW-1];
  wire neg_d = issue_signed & second_source_operand[DW-1];
  wire [DW-1:0] mag_n = neg_n ? (~first_source_operand + {{(DW-1){1'b0}}, 1'b1}) : first_source_operand;
  wire [DW-1:0] mag_d = neg_d ? (~second_source_operand + {{(DW-1){1'b0}}, 1'b1}) : second_source_operand;

  reg [`MDVU_DIV_CNT_W-1:0] skip_nxt;
  reg [`MDVU_DIV_CNT_W-1:0] lat_nxt;
  // Skip and total time follow the dividend width and signedness.
  always @*
  begin
    if (fit8)
    begin
      skip_nxt = `MDVU_DIV_SKIP_8;
      lat_nxt  = issue_signed ? `MDVU_DIV_LAT_S8 : `MDVU_DIV_LAT_U8;
    end
    else if (fit16)
    begin
      skip_nxt = `MDVU_DIV_SKIP_16;
      lat_nxt  = issue_signed ? `MDVU_DIV_LAT_S16 : `MDVU_DIV_LAT_U16;
    end
    else if (fit24)
    begin
      skip_nxt = `MDVU_DIV_SKIP_24;
      lat_nxt  = issue_signed ? `MDVU_DIV_LAT_S24 : `MDVU_DIV_LAT_U24;
    end
    else
    begin
      skip_nxt = {`MDVU_DIV_CNT_W{1'b0}};
      lat_nxt  = issue_signed ? `MDVU_DIV_LAT_S32 : `MDVU_DIV_LAT_U32;
    end
  end

  // ==========================================================
  // Divider state: restoring shift-subtract, one quotient bit a clock.
  reg [`MDVU_DIV_CNT_W-1:0]  iter_r;
  reg [DW-1:0]               rem_r;
  reg [DW-1:0]               dq_r;
  reg [DW-1:0]               dvs_r;
  reg                        qneg_r;
  reg                        rneg_r;
  reg [`MDVU_PAIR_SEL_W-1:0] dpair_r;

  wire [DW:0]   trial  = {rem_r, dq_r[DW-1]} - {1'b0, dvs_r};
  wire          q_bit  = ~trial[DW];
  wire [DW-1:0] q_fix  = qneg_r ? (~dq_r + {{(DW-1){1'b0}}, 1'b1}) : dq_r;
  wire [DW-1:0] r_fix  = rneg_r ? (~rem_r + {{(DW-1){1'b0}}, 1'b1}) : rem_r;
  wire          div_wr = (div_cnt_r == {{(`MDVU_DIV_CNT_W-1){1'b0}}, 1'b1});

  always @(posedge clock)
  begin
    if (rst)
    begin
      div_cnt_r <= {`MDVU_DIV_CNT_W{1'b0}};
      iter_r    <= {`MDVU_DIV_CNT_W{1'b0}};
      rem_r     <= {DW{1'b0}};
      dq_r      <= {DW{1'b0}};
      dvs_r     <= {DW{1'b0}};
      qneg_r    <= 1'b0;
      rneg_r    <= 1'b0;
      dpair_r   <= {`MDVU_PAIR_SEL_W{1'b0}};
      div_done  <= 1'b0;
    end
    else if (ce)
    begin
      div_done <= div_wr;
      if (accept_div)
      begin
        div_cnt_r <= lat_nxt;
        iter_r    <= `MDVU_DIV_ITER_FULL - skip_nxt;
        rem_r     <= {DW{1'b0}};
        dq_r      <= mag_n << skip_nxt;
        dvs_r     <= mag_d;
        qneg_r    <= neg_n ^ neg_d;
        rneg_r    <= neg_n;
        dpair_r   <= issue_pair;
      end
      else
      begin
        if (div_cnt_r != {`MDVU_DIV_CNT_W{1'b0}})
          div_cnt_r <= div_cnt_r - {{(`MDVU_DIV_CNT_W-1){1'b0}}, 1'b1};
        if (iter_r != {`MDVU_DIV_CNT_W{1'b0}})
        begin
          iter_r <= iter_r - {{(`MDVU_DIV_CNT_W-1){1'b0}}, 1'b1};
          rem_r  <= q_bit ? trial[DW-1:0] : {rem_r[DW-2:0], dq_r[DW-1]};
          dq_r   <= {dq_r[DW-2:0], q_bit};
        end
      end
    end
  end

  // ==========================================================
  // Result pairs: divide completion or stage 5 owns the write port.
  wire [PW-1:0]               wr_data = div_wr ? {r_fix, q_fix} : mul_res;
  wire [`MDVU_PAIR_SEL_W-1:0] wr_addr = div_wr ? dpair_r : s5_pair_r;
  wire [PW-1:0]               host_rd;

  mdvu_pair_mem #(
    .DW    (PW),
    .AW    (`MDVU_PAIR_SEL_W),
    .DEPTH (`MDVU_PAIR_COUNT)
  ) u_pairs (
    .clock    (clock),
    .rst      (rst),
    .ce       (ce),
    .wr_en    (div_wr | mul_pair_wr),
    .wr_addr  (wr_addr),
    .wr_data  (wr_data),
    .rda_addr (s4_pair_r),
    .rda_data (acc_rd),
    .rdb_addr (pair_rd_sel),
    .rdb_data (host_rd)
  );

  assign high_result_register = host_rd[PW-1:DW];
  assign low_result_register  = host_rd[DW-1:0];

endmodule
`default_nettype wire

// *** mdvu_pipe_model.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "mdvu_map.vh"
// ==========================================================
// Integer pipeline model: issues work and holds it while stalled.
module mdvu_pipe_model (
  input  wire logic                         clock,
  input  wire logic                         issue_stall,
  output var  logic                         issue_valid,
  output var  logic [`MDVU_OP_W-1:0]        issue_op,
  output var  logic                         issue_signed,
  output var  logic [`MDVU_PAIR_SEL_W-1:0]  issue_pair,
  output var  logic [`MDVU_GPR_IDX_W-1:0]   issue_dest,
  output var  logic [31:0]                  first_source_operand,
  output var  logic [31:0]                  second_source_operand
);
  // The port starts idle.
  initial
  begin
    issue_valid = 1'b0;
    {issue_op, issue_signed, issue_pair, issue_dest} = 11'h000;
    {first_source_operand, second_source_operand} = 64'h0;
  end
  // One request, held whole until an edge finds no stall; waits counts the refused edges.
  task automatic issue(input logic [2:0] op, input logic sgn, input logic [1:0] pr, input logic [4:0] dst,
                       input logic [31:0] a, input logic [31:0] b, output int waits);
    waits = 0;
    @(negedge clock);
    issue_valid = 1'b1;
    {issue_op, issue_signed, issue_pair, issue_dest} = {op, sgn, pr, dst};
    {first_source_operand, second_source_operand} = {a, b};
    @(posedge clock);
    while (issue_stall !== 1'b0 && waits < 60)
    begin
      waits++;
      @(posedge clock);
    end
  endtask
  // Releasing the port leaves no stale operands behind.
  task automatic idle();
    @(negedge clock);
    issue_valid = 1'b0;
    first_source_operand = ~first_source_operand;
    second_source_operand = ~second_source_operand;
  endtask
endmodule
`default_nettype wire

// *** mdvu_core_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "mdvu_map.vh"
// ==========================================================
// Checker on the issue, result and divide status ports.
module mdvu_core_checker #(
  parameter DW = `MDVU_DATA_W
) (
  input  wire logic                        clock,
  input  wire logic                        rst,
  input  wire logic                        ce,
  input  wire logic                        issue_valid,
  input  wire logic [`MDVU_OP_W-1:0]       issue_op,
  input  wire logic [`MDVU_GPR_IDX_W-1:0]  issue_dest,
  input  wire logic                        issue_stall,
  input  wire logic                        gpr_wr_valid,
  input  wire logic [`MDVU_GPR_IDX_W-1:0]  gpr_wr_idx,
  input  wire logic                        div_done,
  input  wire logic                        div_busy
);
  logic       take;
  logic       take_div;
  logic [5:0] busy_cnt_r;
  logic [5:0] busy_cnt_nxt;
  // A request is taken on an enabled edge without stall.
  assign take = issue_valid && !issue_stall && ce;
  assign take_div = take && issue_op == `MDVU_OP_DIV;
  assign busy_cnt_nxt = take_div ? 6'h00 : busy_cnt_r + 6'h01;
  // Counts edges since the last divide was taken.
  always_ff @(posedge clock)
  begin
    if (rst)
      busy_cnt_r <= 6'h00;
    else
      busy_cnt_r <= busy_cnt_nxt;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  stall_rule_a:
    assert property (issue_stall == (issue_valid && div_busy)) else $error("stall not tied to busy request");
  gpr_latency_a:
    assert property (take && issue_op == `MDVU_OP_MUL_GPR |-> ##6 gpr_wr_valid && gpr_wr_idx == $past(issue_dest, 6))
      else $error("register multiply result late or misdirected");
  gpr_cause_a:
    assert property (gpr_wr_valid |-> $past(take && issue_op == `MDVU_OP_MUL_GPR, 6))
      else $error("register write without a matching multiply");
  busy_start_a:
    assert property (take_div |=> div_busy[*8]) else $error("divide not busy after issue");
  done_bound_a:
    assert property (take_div |-> ##[13:39] div_done) else $error("divide did not finish in time");
  done_pulse_a:
    assert property (div_done |=> !div_done) else $error("divide done longer than one cycle");
  lat_set_a:
    assert property (div_done |-> 6'($past(busy_cnt_r) + 6'h01) inside {`MDVU_DIV_LAT_S8, `MDVU_DIV_LAT_U8,
      `MDVU_DIV_LAT_S16, `MDVU_DIV_LAT_U16, `MDVU_DIV_LAT_S24, `MDVU_DIV_LAT_U24, `MDVU_DIV_LAT_S32,
      `MDVU_DIV_LAT_U32}) else $error("divide latency not a listed figure");
  mul_idle_a:
    assert property (take && issue_op != `MDVU_OP_DIV |=> !div_busy) else $error("multiply started divide busy");
  cover property (take && issue_op == `MDVU_OP_MUL_GPR);
  cover property (div_done);
  cover property (issue_stall);
endmodule
bind mdvu_core mdvu_core_checker #(.DW(DW)) u_chk (.clock(clock), .rst(rst), .ce(ce), .issue_valid(issue_valid),
  .issue_op(issue_op), .issue_dest(issue_dest), .issue_stall(issue_stall), .gpr_wr_valid(gpr_wr_valid),
  .gpr_wr_idx(gpr_wr_idx), .div_done(div_done), .div_busy(div_busy));
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "mdvu_map.vh"
module tb;
  logic        clock, rst, ce, issue_valid, issue_signed, issue_stall, gpr_wr_valid, div_done, div_busy, sgn;
  logic [2:0]  issue_op, op;
  logic [1:0]  issue_pair, pair_rd_sel, pr;
  logic [4:0]  issue_dest, gpr_wr_idx, dst;
  logic [31:0] first_source_operand, second_source_operand, gpr_wr_data, hi, lo, a, b, r, m, lfsr_q;
  logic [63:0] exp_pair [4];
  logic [36:0] gq [$];
  int          failures, cmp_count, cyc, i, k, w, n, lat;
  // ==========================================================
  // Clock and instances.
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  mdvu_pipe_model u_pipe (.clock(clock), .issue_stall(issue_stall), .issue_valid(issue_valid), .issue_op(issue_op),
    .issue_signed(issue_signed), .issue_pair(issue_pair), .issue_dest(issue_dest),
    .first_source_operand(first_source_operand), .second_source_operand(second_source_operand));
  mdvu_core dut (.clock(clock), .rst(rst), .ce(ce), .issue_valid(issue_valid), .issue_op(issue_op),
    .issue_signed(issue_signed), .issue_pair(issue_pair), .issue_dest(issue_dest),
    .first_source_operand(first_source_operand), .second_source_operand(second_source_operand),
    .issue_stall(issue_stall), .gpr_wr_valid(gpr_wr_valid), .gpr_wr_idx(gpr_wr_idx), .gpr_wr_data(gpr_wr_data),
    .div_done(div_done), .pair_rd_sel(pair_rd_sel), .high_result_register(hi), .low_result_register(lo),
    .div_busy(div_busy));
  // ==========================================================
  // Helpers that work out expected values.
  function automatic logic [31:0] rnd();
    lfsr_q = {lfsr_q[30:0], ^(lfsr_q & 32'h80200003)};
    return lfsr_q;
  endfunction
  function automatic logic [63:0] ext(input logic s, input logic [31:0] v);
    return {{32{s & v[31]}}, v};
  endfunction
  function automatic logic [63:0] mul_exp(input logic [2:0] o, input logic s, input logic [31:0] x, input logic [31:0] y,
                                          input logic [63:0] acc);
    logic [63:0] p;
    p = ext(s, x) * ext(s, y);
    return (o == 3'h1) ? acc + p : (o == 3'h2) ? acc - p : p;
  endfunction
  function automatic logic [63:0] div_exp(input logic s, input logic [31:0] x, input logic [31:0] y);
    if (s)
      return {32'($signed(x) % $signed(y)), 32'($signed(x) / $signed(y))};
    return {x % y, x / y};
  endfunction
  function automatic int div_lat(input logic s, input logic [31:0] x);
    int sz;
    if (s)
      sz = (x[31:7] == {25{x[7]}}) ? 0 : (x[31:15] == {17{x[15]}}) ? 1 : (x[31:23] == {9{x[23]}}) ? 2 : 3;
    else
      sz = (x[31:8] == 24'h0) ? 0 : (x[31:16] == 16'h0) ? 1 : (x[31:24] == 8'h0) ? 2 : 3;
    return 12 + 8 * sz + (s ? 0 : 2);
  endfunction
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Shows one pair on the read port and compares it.
  task automatic read_pair(input logic [1:0] p);
    @(negedge clock);
    pair_rd_sel = p;
    @(posedge clock);
    #1 check("pair", {hi, lo}, exp_pair[p]);
  endtask
  task automatic conclude();
    if (failures == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Each register multiply result is matched in issue order.
  always @(posedge clock)
  begin
    cyc++;
    if (!rst && gpr_wr_valid === 1'b1)
      check("gpr", {gpr_wr_idx, gpr_wr_data}, gq.size() ? gq.pop_front() : 'x);
    if (cyc == 5000)
    begin
      failures++;
      conclude();
    end
  end
  // ==========================================================
  // Main sequence.
  initial
  begin
    {rst, ce, pair_rd_sel, failures, cmp_count, cyc, lfsr_q} = {1'b1, 1'b1, 2'h0, 96'h0, 32'h00014399};
    for (i = 0; i < 4; i++)
      exp_pair[i] = 64'h0;
    repeat (16) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    // Back-to-back multiplies of every kind, some with narrow second operands.
    for (i = 0; i < 48; i++)
    begin
      r = rnd();
      op = (r[2:0] == 3'h4) ? 3'h3 : r[2:0];
      {dst, pr, sgn} = r[10:3];
      a = rnd();
      b = rnd();
      b = r[11] ? ext(sgn, {16'h0, b[15:0]} | {16'h0, {16{sgn & b[15]}}} << 16) : b;
      u_pipe.issue(op, sgn, pr, dst, a, b, w);
      check("mul stall", w, 0);
      if (op == 3'h3)
        gq.push_back({dst, 32'(mul_exp(3'h0, sgn, a, b, 64'h0))});
      else
        exp_pair[pr] = mul_exp(op, sgn, a, b, exp_pair[pr]);
    end
    u_pipe.idle();
    // Let the last multiplies drain into their pairs before reading.
    repeat (6) @(posedge clock);
    for (i = 0; i < 4; i++)
      read_pair(i[1:0]);
    // Divides of each dividend size, signed and unsigned, each followed by a stalled multiply.
    for (k = 0; k < 8; k++)
    begin
      sgn = k[0];
      pr = k[1:0];
      m = (k >= 6) ? 32'hffffffff : (32'h1 << (8 * (k / 2) + 8)) - 32'h1;
      r = rnd();
      a = (r & m | 32'h1 << (8 * (k / 2) + 7)) & ~(32'h1 << (8 * (k / 2) + 6));
      a = sgn ? a | ~m : a;
      r = rnd();
      b = {{16{r[15]}}, r[15:2], 2'h1};
      u_pipe.issue(3'h4, sgn, pr, 5'h0, a, b, w);
      exp_pair[pr] = div_exp(sgn, a, b);
      lat = div_lat(sgn, a);
      fork
        begin
          n = 0;
          do
          begin
            @(posedge clock);
            n++;
          end while (div_done !== 1'b1 && n < 60);
        end
        u_pipe.issue(3'h0, 1'b0, pr + 2'h1, 5'h0, a, b, w);
      join
      check("div latency", n, lat + 1);
      check("div stall", w, lat - 1);
      exp_pair[pr + 2'h1] = mul_exp(3'h0, 1'b0, a, b, 64'h0);
      u_pipe.idle();
      read_pair(pr);
    end
    // With the enable low the in-flight multiply freezes and a new request is ignored.
    @(negedge clock);
    ce = 1'b0;
    u_pipe.issue(3'h0, 1'b0, 2'h1, 5'h0, 32'h3, 32'h5, w);
    u_pipe.idle();
    repeat (8) @(posedge clock);
    @(negedge clock);
    ce = 1'b1;
    repeat (8) @(posedge clock);
    for (i = 0; i < 4; i++)
      read_pair(i[1:0]);
    conclude();
  end
endmodule
`default_nettype wire
